//--- design/pcs_base_clk_sel.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_base_clk_sel
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // synchronised source clocks and vco run flag
    input  wire logic xtal_s_i,
    input  wire logic vco_s_i,
    input  wire logic vco_run_i,
    // selection
    input  wire logic sel_i,
    output logic      clk_o,
    output logic      busy_o
);
    typedef struct packed {
        pcs_sel_st_t st;
        logic        cur;
        logic        xprev;
        logic        vprev;
        logic [1:0]  xcnt;
        logic [1:0]  vcnt;
        logic        out;
    } pcs_csel_st_t;

    pcs_csel_st_t q, d;
    logic xr, vr;

    always_comb begin
        d       = q;
        xr      = pcs_rise(q.xprev, xtal_s_i);
        vr      = pcs_rise(q.vprev, vco_s_i);
        d.xprev = xtal_s_i;
        d.vprev = vco_s_i;
        case (q.st)
            PCS_SEL_IDLE: begin
                if (sel_i != q.cur) begin
                    d.st   = PCS_SEL_SWITCH;
                    d.xcnt = 2'h0;
                    d.vcnt = 2'h0;
                end else if (q.cur ? vr : xr) begin
                    d.out = ~q.out;
                end
            end
            PCS_SEL_SWITCH: begin
                // output frozen; a stopped vco must not hang the change
                if (xr && q.xcnt != PCS_SW_EDGES) d.xcnt = q.xcnt + 2'h1;
                if (vr && q.vcnt != PCS_SW_EDGES) d.vcnt = q.vcnt + 2'h1;
                if (q.xcnt == PCS_SW_EDGES && (q.vcnt == PCS_SW_EDGES || !vco_run_i)) begin
                    d.st  = PCS_SEL_IDLE;
                    d.cur = sel_i;
                end
            end
            default: d.st = PCS_SEL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q    <= '0;
            q.st <= PCS_SEL_IDLE;
        end else begin
            q <= d;
        end
    end

    assign clk_o  = q.out;
    assign busy_o = (q.st == PCS_SEL_SWITCH);

    property p_hold;
        @(posedge clk_i) disable iff (rst_i) busy_o |=> $stable(clk_o);
    endproperty
    a_hold: assert property (p_hold) else $error("base clock moved during switch");

    c_switch: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy_o));
endmodule
`default_nettype wire

//--- design/pcs_pkg.sv
package pcs_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] PCS_IDX_CTRL = 6'h1c;
    localparam logic [5:0] PCS_IDX_BW   = 6'h1d;
    localparam logic [5:0] PCS_IDX_PROG = 6'h1e;

    // control register fields
    localparam int PCS_CTRL_IE   = 7;
    localparam int PCS_CTRL_FLAG = 6;
    localparam int PCS_CTRL_ON   = 5;
    localparam int PCS_CTRL_BCS  = 4;
    localparam logic [3:0] PCS_CTRL_UNUSED = 4'hf;

    // bandwidth register fields
    localparam int PCS_BW_AUTO = 7;
    localparam int PCS_BW_LOCK = 6;
    localparam int PCS_BW_TRK  = 5;

    // values after reset
    localparam logic       PCS_ON_RST   = 1'b1;
    localparam logic [3:0] PCS_MULT_RST = 4'h6;
    localparam logic [3:0] PCS_RANGE_RST = 4'h6;

    // source change waits this many edges of the crystal, and of the vco while it runs
    localparam logic [1:0] PCS_SW_EDGES = 2'h3;

    // nominal vco centre frequency in hertz
    localparam logic [26:0] PCS_F_NOM_HZ = 27'h04b0000;

    typedef enum logic [1:0] {
        PCS_SEL_IDLE   = 2'b01,
        PCS_SEL_SWITCH = 2'b10
    } pcs_sel_st_t;

    function automatic logic pcs_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    // a multiplier of zero behaves as one
    function automatic logic [3:0] pcs_eff_mult(input logic [3:0] n);
        return (n == 4'h0) ? 4'h1 : n;
    endfunction

endpackage

//--- design/pcs_pll_ctrl.sv
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pcs_pll_ctrl
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // source clocks and stop request
    input  wire logic        crystal_clock_i,
    input  wire logic        vco_clock_i,
    input  wire logic        stop_i,
    // lock detector comparator levels
    input  wire logic        in_lock_tol_i,
    input  wire logic        out_unlock_tol_i,
    input  wire logic        in_trk_tol_i,
    input  wire logic        out_untrk_tol_i,
    // analog and clock controls
    output logic             pll_enable_o,
    output logic             filter_tracking_o,
    output logic      [3:0]  vco_range_o,
    output logic      [26:0] vco_centre_hz_o,
    output logic             vco_feedback_o,
    output logic             base_clock_out_o,
    output logic             clock_switching_o,
    output logic             lock_irq_o
);
    typedef struct packed {
        logic        ack;
        logic [7:0]  rdat;
        logic        lock_irq_enable;
        logic        lock_change_flag;
        logic        pll_power_on;
        logic        base_clock_select;
        logic        auto_bw;
        logic        lock;
        logic        trk_auto;
        logic        trk_man;
        logic        pll_en;
        logic        trk;
        logic [3:0]  mult;
        logic [3:0]  range;
        logic [3:0]  fb_cnt;
        logic        fb;
        logic        vco_prev;
        logic [26:0] centre;
    } pcs_ctrl_st_t;

    pcs_ctrl_st_t q, d;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    logic [5:0] sync_s;
    logic       xtal_s, vco_s, lock_in_s, unlock_s, trk_in_s, untrk_s;

    pcs_sync #(.W(6)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({crystal_clock_i, vco_clock_i, in_lock_tol_i, out_unlock_tol_i,
                   in_trk_tol_i, out_untrk_tol_i}),
        .sync_o  (sync_s)
    );

    assign {xtal_s, vco_s, lock_in_s, unlock_s, trk_in_s, untrk_s} = sync_s;

    ////////////////////////////////////////////////////////////////////////////
    // register access and control

    logic       acc, wr, rd;
    logic [5:0] idx;
    logic [7:0] wdat;
    logic [7:0] ctrl_rd, bw_rd;
    logic [4:0] fb_next;

    assign acc  = wb_cyc_i & wb_stb_i & ~q.ack;
    assign idx  = wb_adr_i[7:2];
    assign wdat = wb_dat_i[7:0];
    assign wr   = acc & wb_we_i & wb_sel_i[0];
    assign rd   = acc & ~wb_we_i;

    // manual mode hides enable and flag
    assign ctrl_rd = {q.auto_bw & q.lock_irq_enable, q.auto_bw & q.lock_change_flag,
                      q.pll_power_on, q.base_clock_select, PCS_CTRL_UNUSED};
    assign bw_rd   = {q.auto_bw, q.auto_bw & q.lock, q.trk, 5'h00};

    always_comb begin
        d       = q;
        fb_next = 5'h00;
        d.ack   = acc;
        d.rdat  = 8'h00;
        if (rd) begin
            case (idx)
                PCS_IDX_CTRL: d.rdat = ctrl_rd;
                PCS_IDX_BW:   d.rdat = bw_rd;
                PCS_IDX_PROG: d.rdat = {q.mult, q.range};
                default:      d.rdat = 8'h00;
            endcase
        end

        if (wr && idx == PCS_IDX_CTRL) begin
            if (q.auto_bw) d.lock_irq_enable = wdat[PCS_CTRL_IE];
            if (!(q.base_clock_select && !wdat[PCS_CTRL_ON])) begin
                d.pll_power_on = wdat[PCS_CTRL_ON];
            end
            // a write that moves power leaves the select alone
            if (d.pll_power_on == q.pll_power_on) begin
                if (!wdat[PCS_CTRL_BCS]) begin
                    d.base_clock_select = 1'b0;
                end else if (q.pll_power_on) begin
                    d.base_clock_select = 1'b1;
                end
            end
        end
        if (wr && idx == PCS_IDX_BW) begin
            d.auto_bw = wdat[PCS_BW_AUTO];
            // manual value kept aside while auto runs
            if (!q.auto_bw) d.trk_man = wdat[PCS_BW_TRK];
        end
        if (wr && idx == PCS_IDX_PROG) begin
            d.mult  = wdat[7:4];
            d.range = wdat[3:0];
        end

        if (d.range == 4'h0 || stop_i) d.base_clock_select = 1'b0;
        d.pll_en = d.pll_power_on & (d.range != 4'h0);
        d.centre = 27'(q.range * PCS_F_NOM_HZ);

        // lock detector with hysteresis between enter and leave tolerances
        if (q.auto_bw && q.pll_en) begin
            if (lock_in_s) d.lock = 1'b1;
            else if (unlock_s) d.lock = 1'b0;
            if (trk_in_s) d.trk_auto = 1'b1;
            else if (untrk_s) d.trk_auto = 1'b0;
        end else begin
            d.lock     = 1'b0;
            d.trk_auto = 1'b0;
        end
        d.trk = d.auto_bw ? d.trk_auto : d.trk_man;

        // flag: a toggle in the same cycle as the read wins
        if (rd && idx == PCS_IDX_CTRL) d.lock_change_flag = 1'b0;
        if (q.auto_bw && d.lock != q.lock) d.lock_change_flag = 1'b1;
        if (!q.auto_bw) d.lock_change_flag = 1'b0;

        // modulo feedback divider, one pulse per N vco edges
        d.vco_prev = vco_s;
        d.fb       = 1'b0;
        if (q.pll_en && pcs_rise(q.vco_prev, vco_s)) begin
            fb_next = {1'b0, q.fb_cnt} + 5'h01;
            if (fb_next >= {1'b0, pcs_eff_mult(q.mult)}) begin
                d.fb_cnt = 4'h0;
                d.fb     = 1'b1;
            end else begin
                d.fb_cnt = fb_next[3:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q              <= '0;
            q.pll_power_on <= PCS_ON_RST;
            q.pll_en       <= PCS_ON_RST;
            q.mult         <= PCS_MULT_RST;
            q.range        <= PCS_RANGE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // base clock selector

    pcs_base_clk_sel u_clk_sel (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .xtal_s_i  (xtal_s),
        .vco_s_i   (vco_s),
        .vco_run_i (q.pll_en),
        .sel_i     (q.base_clock_select),
        .clk_o     (base_clock_out_o),
        .busy_o    (clock_switching_o)
    );

    assign wb_ack_o          = q.ack;
    assign wb_dat_o          = {24'h000000, q.rdat};
    assign pll_enable_o      = q.pll_en;
    assign filter_tracking_o = q.trk;
    assign vco_range_o       = q.range;
    assign vco_centre_hz_o   = q.centre;
    assign vco_feedback_o    = q.fb;
    // interrupts exist only in auto mode
    assign lock_irq_o = q.auto_bw & q.lock_irq_enable & q.lock_change_flag;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_irq_manual;
        @(posedge clk_i) disable iff (rst_i) !q.auto_bw |-> !lock_irq_o;
    endproperty
    a_irq_manual: assert property (p_irq_manual) else $error("irq in manual mode");

    property p_bcs_needs_on;
        @(posedge clk_i) disable iff (rst_i) q.base_clock_select |-> q.pll_power_on;
    endproperty
    a_bcs_needs_on: assert property (p_bcs_needs_on) else $error("vco selected while off");

    property p_on_hold;
        @(posedge clk_i) disable iff (rst_i)
            (q.base_clock_select && wr && idx == PCS_IDX_CTRL) |=> q.pll_power_on;
    endproperty
    a_on_hold: assert property (p_on_hold) else $error("power cleared while vco selected");

    property p_no_joint;
        @(posedge clk_i) disable iff (rst_i)
            $changed(q.pll_power_on) |-> !$rose(q.base_clock_select);
    endproperty
    a_no_joint: assert property (p_no_joint) else $error("power and select changed together");

    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
            ($past(q.auto_bw) && $changed(q.lock)) |-> q.lock_change_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("lock toggle did not set flag");

    property p_range0;
        @(posedge clk_i) disable iff (rst_i)
            (q.range == 4'h0) |-> (!q.base_clock_select && !pll_enable_o);
    endproperty
    a_range0: assert property (p_range0) else $error("zero range left pll usable");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i) stop_i |=> !q.base_clock_select;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left vco selected");

    property p_manual_lock;
        @(posedge clk_i) disable iff (rst_i) !q.auto_bw |=> (bw_rd[PCS_BW_LOCK] == 1'b0);
    endproperty
    a_manual_lock: assert property (p_manual_lock) else $error("lock shown in manual mode");

    property p_lock_manual;
        @(posedge clk_i) disable iff (rst_i)
            !q.auto_bw |=> !q.lock;
    endproperty
    a_lock_manual: assert property (p_lock_manual) else $error("lock held in manual mode");

    property p_irq_toggle;
        @(posedge clk_i) disable iff (rst_i)
            (q.auto_bw && q.lock_irq_enable && $past(q.auto_bw) && $changed(q.lock))
                |-> lock_irq_o;
    endproperty
    a_irq_toggle: assert property (p_irq_toggle) else $error("lock toggle raised no irq");

    property p_man_trk_set;
        @(posedge clk_i) disable iff (rst_i)
            (!q.auto_bw && wr && idx == PCS_IDX_BW && !wdat[PCS_BW_AUTO] && wdat[PCS_BW_TRK])
                |=> filter_tracking_o;
    endproperty
    a_man_trk_set: assert property (p_man_trk_set) else $error("manual tracking not applied");

    property p_man_acq_set;
        @(posedge clk_i) disable iff (rst_i)
            (!q.auto_bw && wr && idx == PCS_IDX_BW && !wdat[PCS_BW_AUTO] && !wdat[PCS_BW_TRK])
                |=> !filter_tracking_o;
    endproperty
    a_man_acq_set: assert property (p_man_acq_set) else $error("manual acquisition not applied");

    property p_lock_set;
        @(posedge clk_i) disable iff (rst_i)
            (q.auto_bw && q.pll_en && lock_in_s) |=> q.lock;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set inside tolerance");

    property p_lock_clear;
        @(posedge clk_i) disable iff (rst_i)
            (q.auto_bw && q.pll_en && !lock_in_s && unlock_s) |=> !q.lock;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock kept outside tolerance");

    property p_trk_set;
        @(posedge clk_i) disable iff (rst_i)
            (q.auto_bw && q.pll_en && trk_in_s) |=> q.trk_auto;
    endproperty
    a_trk_set: assert property (p_trk_set) else $error("tracking not set in auto mode");

    property p_flag_rd_clear;
        @(posedge clk_i) disable iff (rst_i)
            (rd && idx == PCS_IDX_CTRL) ##1 $stable(q.lock) |-> !q.lock_change_flag;
    endproperty
    a_flag_rd_clear: assert property (p_flag_rd_clear) else $error("flag survived read");

    property p_select_refused;
        @(posedge clk_i) disable iff (rst_i)
            (wr && idx == PCS_IDX_CTRL && !q.pll_power_on) |=> !q.base_clock_select;
    endproperty
    a_select_refused: assert property (p_select_refused) else $error("select taken while off");

    property p_power_write_alone;
        @(posedge clk_i) disable iff (rst_i)
            (wr && idx == PCS_IDX_CTRL && !q.base_clock_select
             && wdat[PCS_CTRL_ON] != q.pll_power_on) |=> !q.base_clock_select;
    endproperty
    a_power_write_alone: assert property (p_power_write_alone) else $error("joint write");

    property p_fb_off;
        @(posedge clk_i) disable iff (rst_i)
            !q.pll_en |=> !vco_feedback_o;
    endproperty
    a_fb_off: assert property (p_fb_off) else $error("feedback pulse with pll off");

    c_flag: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_irq_o));
    c_vco_sel: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q.base_clock_select));
    c_fb: cover property (@(posedge clk_i) disable iff (rst_i) q.fb);
endmodule
`default_nettype wire

//--- design/pcs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_sync
    import pcs_pkg::*;
#(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] stg1;
        logic [W-1:0] stg2;
    } pcs_sync_st_t;

    pcs_sync_st_t q, d;

    always_comb begin
        d      = q;
        d.stg1 = async_i;
        d.stg2 = q.stg1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stg2;
endmodule
`default_nettype wire

//--- test/pcs_pll_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_pll_ctrl_tb_top
    import pcs_pkg::*;
;
    localparam logic [7:0] A_CTRL = {PCS_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_BW   = {PCS_IDX_BW, 2'b00};
    localparam logic [7:0] A_PROG = {PCS_IDX_PROG, 2'b00};
    localparam logic [7:0] A_NONE = 8'h7c;
    // short stand-ins for the analog settling times, which the logic never sees
    localparam int ACQ_WAIT           = 40;
    localparam int TRACK_TO_LOCK_WAIT = 40;

    logic        clk_i           = 1'b0;
    logic        rst_i           = 1'b1;
    logic        wb_cyc_i        = 1'b0;
    logic        wb_stb_i        = 1'b0;
    logic        wb_we_i         = 1'b0;
    logic [7:0]  wb_adr_i        = 8'h00;
    logic [3:0]  wb_sel_i        = 4'h0;
    logic [31:0] wb_dat_i        = 32'h0;
    logic        crystal_clock_i = 1'b0;
    logic        vco_clock_i     = 1'b0;
    logic        stop_i          = 1'b0;
    // in_lock, out_unlock, in_trk, out_untrk
    logic [3:0]  tol_q           = 4'h0;
    logic [31:0] wb_dat_o;
    logic [26:0] vco_centre_hz_o;
    logic [3:0]  vco_range_o;
    logic        wb_ack_o, pll_enable_o, filter_tracking_o, vco_feedback_o;
    logic        base_clock_out_o, clock_switching_o, lock_irq_o, bprev_q;
    logic        m_ie = 1'b0, m_on = 1'b1, m_bcs = 1'b0, m_auto = 1'b0, m_trk = 1'b0;
    logic [3:0]  m_n = 4'h6, m_l = 4'h6;
    int          miscompares = 0, checks = 0, seed = 29197;
    int          xc = 0, vc = 0, xr = 0, vr = 0, btog = 0, fbn = 0;

    pcs_pll_ctrl uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_clock_i(crystal_clock_i),
        .vco_clock_i(vco_clock_i), .stop_i(stop_i), .in_lock_tol_i(tol_q[3]),
        .out_unlock_tol_i(tol_q[2]), .in_trk_tol_i(tol_q[1]), .out_untrk_tol_i(tol_q[0]),
        .pll_enable_o(pll_enable_o), .filter_tracking_o(filter_tracking_o),
        .vco_range_o(vco_range_o), .vco_centre_hz_o(vco_centre_hz_o),
        .vco_feedback_o(vco_feedback_o), .base_clock_out_o(base_clock_out_o),
        .clock_switching_o(clock_switching_o), .lock_irq_o(lock_irq_o)
    );

    always #2 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////////////
    // crystal period 6 cycles, vco period 8: distinct rates expose a wrong source pick
    always @(posedge clk_i) begin
        xc <= (xc == 2) ? 0 : xc + 1;
        vc <= (vc == 3) ? 0 : vc + 1;
        if (xc == 2) begin
            crystal_clock_i <= ~crystal_clock_i;
            if (!crystal_clock_i) xr <= xr + 1;
        end
        if (vc == 3) begin
            vco_clock_i <= ~vco_clock_i;
            if (!vco_clock_i) vr <= vr + 1;
        end
        bprev_q <= base_clock_out_o;
        if (base_clock_out_o !== bprev_q) btog <= btog + 1;
        if (vco_feedback_o === 1'b1) fbn <= fbn + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic err(input string m);
        miscompares++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) err($sformatf("%s got %h want %h", what, got, exp));
    endtask

    // edge sampling of asynchronous sources can gain or lose one count per window
    task automatic chkn(input int got, input int exp, input int tol, input string what);
        checks++;
        if (got < exp - tol || got > exp + tol) err($sformatf("%s %0d vs %0d", what, got, exp));
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        // no own limit: the watchdog ends a hung cycle
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, adr, d, q);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string what);
        logic [7:0] q;
        wb(1'b0, adr, 8'h00, q);
        chkv(32'(q), 32'(exp), what);
    endtask

    function automatic logic [7:0] ctrl_x(input logic f);
        return {m_auto & m_ie, m_auto & f, m_on, m_bcs, 4'hf};
    endfunction

    function automatic logic [7:0] bw_x(input logic lk, input logic tk);
        return {m_auto, m_auto & lk, m_auto ? tk : m_trk, 5'h00};
    endfunction

    // control write as the model sees it
    task automatic wctrl(input logic [7:0] d);
        logic on;
        on = d[5] | m_bcs;
        if (m_auto) m_ie = d[7];
        if (on == m_on && !(d[4] && (!m_on || m_l == 4'h0))) m_bcs = d[4];
        m_on = on;
        wr(A_CTRL, d);
    endtask

    task automatic sw_wait(output int n, output logic st);
        logic b0;
        n = 0;
        st = 1'b1;
        repeat (3) @(posedge clk_i);
        b0 = base_clock_out_o;
        while (clock_switching_o === 1'b1 && n < 80) begin
            @(posedge clk_i);
            n++;
            if (base_clock_out_o !== b0) st = 1'b0;
        end
    endtask

    task automatic pulse_tol(input logic [3:0] v);
        @(posedge clk_i);
        tol_q <= v;
        repeat (6) @(posedge clk_i);
        tol_q <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic toggles(input bit vco, input string what);
        int a, b;
        a = vco ? vr : xr;
        b = btog;
        repeat (160) @(posedge clk_i);
        chkn(btog - b, (vco ? vr : xr) - a, 1, what);
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clk_i);
        err("watchdog expired");
        summarize();
    end

    initial begin
        logic [7:0] d;
        int         n, a, b;
        logic       st;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_CTRL, 8'h2f, "ctrl reset");
        rd(A_BW, 8'h00, "bw reset");
        rd(A_PROG, 8'h66, "prog reset");
        wr(A_NONE, 8'hff);
        rd(A_NONE, 8'h00, "unmapped");
        chkv(32'(filter_tracking_o), 32'h0, "acq after reset");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            if (i == 0) d[7:4] = 4'h0;
            if (d[3:0] == 4'h0) d[3:0] = 4'h1;
            wr(A_PROG, d);
            m_n = d[7:4];
            m_l = d[3:0];
            rd(A_PROG, d, "prog readback");
            chkv(32'(vco_range_o), 32'(m_l), "range");
            chkv(32'(vco_centre_hz_o), 32'(m_l) * 32'd4915200, "centre");
            a = vr;
            b = fbn;
            repeat (200) @(posedge clk_i);
            chkn(fbn - b, (vr - a) / ((m_n == 4'h0) ? 1 : int'(m_n)), 1, "feedback");
        end
        $display("test programming done");
        wctrl(8'h0f);
        rd(A_CTRL, ctrl_x(1'b0), "power off");
        wctrl(8'h1f);
        rd(A_CTRL, ctrl_x(1'b0), "select refused");
        wctrl(8'h3f);
        rd(A_CTRL, ctrl_x(1'b0), "power with select");
        repeat (ACQ_WAIT) @(posedge clk_i);
        wr(A_BW, 8'h20);
        m_trk = 1'b1;
        repeat (TRACK_TO_LOCK_WAIT) @(posedge clk_i);
        wctrl(8'h3f);
        rd(A_CTRL, ctrl_x(1'b0), "select vco");
        sw_wait(n, st);
        chkv(32'(st), 32'h1, "frozen to vco");
        chkn(n, 20, 10, "switch length to vco");
        toggles(1'b1, "vco divide");
        wctrl(8'h0f);
        rd(A_CTRL, ctrl_x(1'b0), "power clear ignored");
        sw_wait(n, st);
        chkv(32'(st), 32'h1, "frozen to crystal");
        toggles(1'b0, "crystal divide");
        wctrl(8'h3f);
        sw_wait(n, st);
        @(posedge clk_i);
        stop_i <= 1'b1;
        @(posedge clk_i);
        stop_i <= 1'b0;
        m_bcs = 1'b0;
        rd(A_CTRL, ctrl_x(1'b0), "stop clears select");
        sw_wait(n, st);
        wr(A_PROG, {m_n, 4'h0});
        m_l = 4'h0;
        wctrl(8'h3f);
        rd(A_CTRL, ctrl_x(1'b0), "select with zero range");
        chkv(32'(pll_enable_o), 32'h0, "zero range disables");
        wr(A_PROG, 8'h66);
        m_n = 4'h6;
        m_l = 4'h6;
        $display("test select done");
        wr(A_BW, 8'h20);
        m_trk = 1'b1;
        rd(A_BW, bw_x(1'b0, 1'b0), "manual tracking");
        chkv(32'(filter_tracking_o), 32'h1, "filter tracking");
        wr(A_BW, 8'h00);
        m_trk = 1'b0;
        chkv(32'(filter_tracking_o), 32'h0, "filter acquisition");
        wctrl(8'haf);
        rd(A_CTRL, ctrl_x(1'b0), "enable ignored manual");
        wr(A_BW, 8'h20);
        m_trk = 1'b1;
        pulse_tol(4'b1010);
        chkv(32'(lock_irq_o), 32'h0, "no irq manual");
        rd(A_BW, bw_x(1'b1, 1'b1), "no lock manual");
        $display("test manual done");
        // a write taken in manual mode also stores the manual tracking value
        wr(A_BW, 8'ha0);
        m_auto = 1'b1;
        wctrl(8'ha0);
        pulse_tol(4'b1010);
        chkv(32'(lock_irq_o), 32'h1, "irq on lock");
        chkv(32'(filter_tracking_o), 32'h1, "auto tracking");
        rd(A_BW, bw_x(1'b1, 1'b1), "locked");
        wr(A_BW, 8'h80);
        rd(A_BW, bw_x(1'b1, 1'b1), "tracking read only");
        rd(A_CTRL, ctrl_x(1'b1), "flag set");
        rd(A_CTRL, ctrl_x(1'b0), "flag cleared");
        chkv(32'(lock_irq_o), 32'h0, "irq gone");
        pulse_tol(4'b0101);
        rd(A_BW, bw_x(1'b0, 1'b0), "unlocked");
        chkv(32'(filter_tracking_o), 32'h0, "auto acquisition");
        rd(A_CTRL, ctrl_x(1'b1), "flag on unlock");
        wr(A_BW, 8'h00);
        m_auto = 1'b0;
        rd(A_BW, bw_x(1'b0, 1'b0), "manual value kept");
        rd(A_CTRL, ctrl_x(1'b0), "manual hides flag");
        $display("test auto done");
        summarize();
    end
endmodule
`default_nettype wire
